// file: hw/csi_defs.vh
`ifndef CSI_DEFS_VH
`define CSI_DEFS_VH
// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define MODE_ENABLE_BIT 7
`define MODE_TRMD_BIT 6
`define MODE_SLAVE_BIT 5
`define MODE_DIR_BIT 4
`define MODE_RESET_VAL 8'h00
// ----------------------------------------
// Clock select fields
// ----------------------------------------
`define CLKSEL_PHASE_BIT 4
`define CLKSEL_DAP_BIT 3
`define CLKSEL_DIV_MSB 2
`define CLKSEL_DIV_LSB 0
`define CLKSEL_RESET_VAL 8'h00
`define PHASE_TYPE1 1'b0
`define BITS_PER_BYTE 4'h8
`endif

// file: hw/csi_divider.v
module csi_divider
(
	input wire core_clk_i,
	input wire reset_i,
	input wire run_i,
	input wire [2:0] sel_i,
	output reg tick_o
);
	reg [7:0] cnt_r;
	wire [7:0] limit;
	assign limit = (8'h01 << sel_i) - 8'h01;
	always @(posedge core_clk_i)
	begin
		if (reset_i || !run_i)
		begin
			cnt_r <= 8'h00;
			tick_o <= 1'b0;
		end
		else if (cnt_r >= limit)
		begin
			cnt_r <= 8'h00;
			tick_o <= 1'b1;
		end
		else
		begin
			cnt_r <= cnt_r + 8'h01;
			tick_o <= 1'b0;
		end
	end
endmodule // csi_divider

// file: hw/csi_channel.v
`include "csi_defs.vh"
module csi_channel
#(
	parameter HAS_SSI = 1
)
(
	input wire core_clk_i,
	input wire reset_i,
	input wire [7:0] mode_wdata_i,
	input wire mode_we_i,
	input wire [7:0] clksel_wdata_i,
	input wire clksel_we_i,
	input wire [7:0] data_wdata_i,
	input wire data_we_i,
	input wire osc_clk_sel_i,
	input wire sck_i,
	input wire si_i,
	input wire slave_select_input_n_i,
	input wire [7:0] port_out_i,
	output reg sck_o,
	output reg sck_oe_n_o,
	output reg serial_data_out_o,
	output reg so_oe_n_o,
	output reg transfer_active_flag_o,
	output reg [7:0] serial_shift_reg_o,
	output reg [7:0] mode_o,
	output reg [7:0] clksel_o,
	output reg done_o,
	output reg unguaranteed_o
);
	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam ST_IDLE = 2'b01;
	localparam ST_SHIFT = 2'b10;
	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [3:0] bit_cnt_r;
	reg half_r;
	reg sck_in_d_r;
	reg [7:0] shreg_r;
	wire tick;
	wire enable = mode_o[`MODE_ENABLE_BIT];
	wire slave = mode_o[`MODE_SLAVE_BIT];
	wire trmd = mode_o[`MODE_TRMD_BIT];
	wire lsb_first = mode_o[`MODE_DIR_BIT];
	wire phase = clksel_o[`CLKSEL_PHASE_BIT];
	wire dap = clksel_o[`CLKSEL_DAP_BIT];
	wire selected = (HAS_SSI == 0) || !slave || !slave_select_input_n_i;
	wire active = enable && selected;
	wire sck_rise = sck_i && !sck_in_d_r;
	wire sck_fall = !sck_i && sck_in_d_r;
	wire lead = slave ? (dap ? sck_rise : sck_fall) : (tick && !half_r);
	wire trail = slave ? (dap ? sck_fall : sck_rise) : (tick && half_r);
	// ----------------------------------------
	// Output bit select
	// ----------------------------------------
	function out_bit;
		input [7:0] v;
		input lsb;
		out_bit = lsb ? v[0] : v[7];
	endfunction
	csi_divider u_div
	(
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.run_i(state_r == ST_SHIFT && !slave),
		.sel_i(clksel_o[`CLKSEL_DIV_MSB:`CLKSEL_DIV_LSB]),
		.tick_o(tick)
	);
	always @*
	begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:
			begin
				if (data_we_i && enable)
					state_nxt = ST_SHIFT;
			end
			ST_SHIFT:
			begin
				if (!active)
					state_nxt = ST_IDLE;
				else if (trail && bit_cnt_r == `BITS_PER_BYTE - 4'h1)
					state_nxt = ST_IDLE;
			end
			default:
				state_nxt = ST_IDLE;
		endcase
	end
	// ----------------------------------------
	// Registers and shifting
	// ----------------------------------------
	always @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			state_r <= ST_IDLE;
			mode_o <= `MODE_RESET_VAL;
			clksel_o <= `CLKSEL_RESET_VAL;
			bit_cnt_r <= 4'h0;
			half_r <= 1'b0;
			sck_in_d_r <= 1'b1;
			shreg_r <= 8'h00;
			transfer_active_flag_o <= 1'b0;
			done_o <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			sck_in_d_r <= sck_i;
			done_o <= 1'b0;
			if (mode_we_i)
				mode_o <= mode_wdata_i;
			if (clksel_we_i && !enable)
				clksel_o <= clksel_wdata_i;
			if (state_r == ST_IDLE)
			begin
				bit_cnt_r <= 4'h0;
				half_r <= 1'b0;
				if (data_we_i && enable)
				begin
					shreg_r <= data_wdata_i;
					transfer_active_flag_o <= 1'b1;
				end
			end
			else
			begin
				if (lead && !slave)
					half_r <= 1'b1;
				if (trail)
				begin
					half_r <= 1'b0;
					bit_cnt_r <= bit_cnt_r + 4'h1;
					shreg_r <= lsb_first ? {si_i, shreg_r[7:1]} : {shreg_r[6:0], si_i};
				end
				if (state_nxt == ST_IDLE)
				begin
					transfer_active_flag_o <= 1'b0;
					done_o <= 1'b1;
				end
			end
		end
	end
	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	always @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			sck_o <= 1'b1;
			sck_oe_n_o <= 1'b1;
			serial_data_out_o <= 1'b0;
			so_oe_n_o <= 1'b1;
			serial_shift_reg_o <= 8'h00;
			unguaranteed_o <= 1'b0;
		end
		else
		begin
			serial_shift_reg_o <= shreg_r;
			unguaranteed_o <= osc_clk_sel_i;
			if (!phase)
			begin
				sck_o <= port_out_i[0];
				sck_oe_n_o <= 1'b1;
				serial_data_out_o <= port_out_i[2];
				so_oe_n_o <= 1'b1;
			end
			else
			begin
				sck_oe_n_o <= slave;
				sck_o <= (state_r == ST_SHIFT) ? (half_r ^ ~dap) : 1'b1;
				so_oe_n_o <= !(trmd && selected);
				serial_data_out_o <= trmd ? out_bit(shreg_r, lsb_first) : 1'b0;
			end
		end
	end
endmodule // csi_channel

// file: tb/csi_channel_assertions.sv
module csi_checker
(
	input wire core_clk_i,
	input wire reset_i,
	input wire data_we_i,
	input wire osc_clk_sel_i,
	input wire slave_select_input_n_i,
	input wire [7:0] port_out_i,
	input wire sck_o,
	input wire serial_data_out_o,
	input wire transfer_active_flag_o,
	input wire [7:0] mode_o,
	input wire [7:0] clksel_o,
	input wire done_o,
	input wire unguaranteed_o
);
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (reset_i);
	property p_rst;
		$past(reset_i) |-> clksel_o == 8'h00;
	endproperty
	a_rst: assert property (p_rst) else $error("phase not reset");
	property p_gpio;
		(!clksel_o[4] && $stable(port_out_i))[*3] |-> {sck_o, serial_data_out_o} == {port_out_i[0], port_out_i[2]};
	endproperty
	a_gpio: assert property (p_gpio) else $error("pins not port");
	property p_osc;
		osc_clk_sel_i[*2] |-> unguaranteed_o;
	endproperty
	a_osc: assert property (p_osc) else $error("osc flag");
	property p_ssel;
		mode_o[7] && mode_o[5] && slave_select_input_n_i && transfer_active_flag_o |-> ##[0:2] !transfer_active_flag_o;
	endproperty
	a_ssel: assert property (p_ssel) else $error("deselect");
	property p_start;
		data_we_i && mode_o[7] && !mode_o[5] && !transfer_active_flag_o |=> transfer_active_flag_o;
	endproperty
	a_start: assert property (p_start) else $error("no start");
	property p_end;
		$fell(transfer_active_flag_o) && !mode_o[5] |-> ##[0:1] done_o;
	endproperty
	a_end: assert property (p_end) else $error("no done");
	cover property ($fell(transfer_active_flag_o));
	cover property (unguaranteed_o);
	cover property (!clksel_o[4] && port_out_i[0]);
endmodule // csi_checker
bind csi_channel csi_checker csi_checker_inst (.*);

// file: tb/serial_peer.sv
module serial_peer
(
	input wire core_clk_i,
	input wire sck_i,
	input wire sck_oe_n_i,
	output logic si_o,
	output int edges_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic sck_q = 1'b1;
	initial si_o = 1'b0;
	initial edges_o = 0;
	// Count rising clock edges while clock is driven, toggle data
	always @(posedge core_clk_i)
	begin
		sck_q <= sck_i;
		if (!sck_oe_n_i && sck_i && !sck_q)
		begin
			edges_o <= edges_o + 1;
			si_o <= ~si_o;
		end
	end
endmodule // serial_peer

// file: tb/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, mwe = 0, cwe = 0, dwe = 0, osc = 0, ssel_n = 1, si;
	logic sck, sck_oe_n, so, flag, done, ung, soe_n;
	logic [7:0] wd = 8'h00, port = 8'h00, mode, cs, shr;
	int failures = 0, check_count = 0, edges, cyc = 0;
	csi_channel csi_channel_inst (.core_clk_i(clk), .reset_i(rst), .mode_wdata_i(wd), .mode_we_i(mwe),
		.clksel_wdata_i(wd), .clksel_we_i(cwe), .data_wdata_i(wd), .data_we_i(dwe), .osc_clk_sel_i(osc),
		.sck_i(1'b1), .si_i(si), .slave_select_input_n_i(ssel_n), .port_out_i(port), .sck_o(sck),
		.sck_oe_n_o(sck_oe_n), .serial_data_out_o(so), .so_oe_n_o(soe_n), .transfer_active_flag_o(flag),
		.serial_shift_reg_o(shr), .mode_o(mode), .clksel_o(cs), .done_o(done), .unguaranteed_o(ung));
	serial_peer serial_peer_inst (.core_clk_i(clk), .sck_i(sck), .sck_oe_n_i(sck_oe_n), .si_o(si), .edges_o(edges));
	initial forever #50 clk = ~clk;
	task chk(input string n, input logic [7:0] s, e);
		check_count++;
		if (s !== e)
		begin
			failures++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task wr(input int k, input logic [7:0] v);
		@(posedge clk);
		wd <= v;
		mwe <= k == 0;
		cwe <= k == 1;
		dwe <= k == 2;
		@(posedge clk);
		{mwe, cwe, dwe} <= 3'b000;
	endtask
	task results;
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			failures++;
			results();
		end
	end
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 0;
		port <= 8'h05;
		repeat (5) @(posedge clk);
		#1 chk("clksel", cs, 8'h00);
		chk("pins", {6'h00, sck, so}, 8'h03);
		$display("test reset done");
		wr(1, 8'h10);
		wr(0, 8'hC0);
		wr(2, 8'hA5);
		#1 chk("busy", {7'h00, flag}, 8'h01);
		chk("so_oe", {7'h00, soe_n}, 8'h00);
		for (int i = 0; i < 200 && flag !== 1'b0; i++) @(posedge clk);
		#1 chk("busy", {7'h00, flag}, 8'h00);
		repeat (3) @(posedge clk);
		#1 chk("edges", edges[7:0], 8'h08);
		chk("shift", shr, 8'h2A);
		$display("test transfer done");
		wr(1, 8'h13);
		#1 chk("clksel", cs, 8'h10);
		osc <= 1;
		repeat (3) @(posedge clk);
		#1 chk("osc", {7'h00, ung}, 8'h01);
		osc <= 0;
		$display("test lock done");
		wr(0, 8'h00);
		wr(0, 8'hE0);
		wr(2, 8'h5A);
		repeat (3) @(posedge clk);
		#1 chk("busy", {7'h00, flag}, 8'h00);
		$display("test slave done");
		results();
	end
endmodule // tb
